// *** rtl/ifp_map.svh ***
// offsets, field positions, reset values of the force/level/priority block
// assumes: 32-bit register words, byte addressing, 12-bit bus address
`ifndef IFP_MAP_SVH
`define IFP_MAP_SVH

// ****************************************
// register offsets
// ****************************************
`define IFP_OFF_FORCE_HIGH 12'h000
`define IFP_OFF_FORCE_LOW 12'h004
`define IFP_OFF_MASK_HIGH 12'h008
`define IFP_OFF_MASK_LOW 12'h00c
`define IFP_OFF_PEND_HIGH 12'h010
`define IFP_OFF_PEND_LOW 12'h014
`define IFP_OFF_LEVEL_SUM 12'h018
`define IFP_OFF_ACK_LP 12'h01c
// control words: base + 4 * source number
`define IFP_PAGE_ICR 4'h1

// ****************************************
// field positions
// ****************************************
`define IFP_ICR_LVL_MSB 5
`define IFP_ICR_LVL_LSB 3
`define IFP_ICR_PRI_MSB 2
`define IFP_ICR_PRI_LSB 0
`define IFP_ICR_WMASK 8'h3f
`define IFP_FORCE_LOW_WMASK 32'hffff_fffe
`define IFP_ICR_FIRST_RW 6'h08
`define IFP_PRI_MID 4'h8
`define IFP_RANK_MID 4'h7

// ****************************************
// reset values and bus answers
// ****************************************
`define IFP_MASK_RESET 64'hffff_ffff_ffff_ffff
`define IFP_FORCE_RESET 64'h0000_0000_0000_0000
`define IFP_ICR_RESET 8'h00
`define IFP_RESP_OKAY 2'h0
`define IFP_RESP_DECERR 2'h3

`endif

// *** rtl/ifp_pkg.sv ***
// types shared by the force/level/priority block
// assumes: 64 sources, source 0 unused, sources 1..7 fixed level
package ifp_pkg;

    // one control byte per source
    typedef logic [63:0][7:0] ifp_icr_arr_t;

    // winner of an acknowledge search
    typedef struct packed {
        logic found;
        logic [5:0] src;
        logic [3:0] acked_priority_field;
    } ifp_win_t;

    // whole state of the top module
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_held;
        logic [11:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [63:0] force_bits;
        logic [63:0] mask;
        logic [63:0] req_meta;
        logic [63:0] pend;
        logic [7:1] peer_meta;
        logic [7:1] peer;
        logic [7:1] summary;
        logic [2:0] ipl;
        logic ack_done;
        logic [7:0] ack_vector;
        logic [7:0] ack_lp;
        ifp_icr_arr_t icr;
    } ifp_state_t;

endpackage : ifp_pkg

// *** rtl/ifp_arbiter.sv ***
// search for the best requester within one level
// assumes: control bytes already show fixed sources as level=n, pri=0
`timescale 1ns/10ps
`default_nettype none
`include "ifp_map.svh"

module ifp_arbiter
    import ifp_pkg::*;
(
    // requests and control bytes
    input wire logic [63:0] active,
    input wire ifp_icr_arr_t icr,
    // level under acknowledge
    input wire logic [2:0] level,
    // winner
    output ifp_win_t win
);

    // ****************************************
    // search
    // ****************************************
    // highest rank wins; fixed sources rank between 3 and 4
    always_comb begin
        logic [3:0] rank;
        logic [3:0] best;
        logic fixed;
        rank = 4'h0;
        best = 4'h0;
        fixed = 1'b0;
        win = '0;
        for (int i = 1; i < 64; i++) begin
            fixed = (i < 8);
            rank = fixed ? `IFP_RANK_MID :
                {icr[i][`IFP_ICR_PRI_MSB:`IFP_ICR_PRI_LSB], 1'b0};
            if (active[i] && (level != 3'h0) &&
                icr[i][`IFP_ICR_LVL_MSB:`IFP_ICR_LVL_LSB] == level &&
                (!win.found || rank > best)) begin
                best = rank;
                win.found = 1'b1;
                win.src = 6'(i);
                win.acked_priority_field = fixed ? `IFP_PRI_MID :
                    {1'b0, icr[i][`IFP_ICR_PRI_MSB:`IFP_ICR_PRI_LSB]};
            end
        end
    end

endmodule : ifp_arbiter
`default_nettype wire

// *** rtl/ifp_top.sv ***
// force, level summary, acknowledge capture and source control registers
// assumes: AXI4-Lite master on aclk, requests from outside the domain,
// acknowledge strobe from the core on aclk
//
// Operation
// - two 32-bit force registers, one bit per source
// - forced requests bypass the mask
// - force registers clear on reset
// - low force bit 0 reserved, kept clear
// - level summary refreshed every cycle
// - summary bit set if level has request
// - merge peer levels, encode 3-bit level
// - acknowledge returns best source vector
// - acknowledge loads level/priority register
// - level bits 6:4, priority bits 3:0
// - priority 8 only for fixed sources
// - control gives level 1-7, priority 0-7
// - controls readable, writable for 8..63 only
// - reset control value disables source
// - level bits 5:3, priority 2:0
// - priority 111b highest, 000b lowest
// - fixed sources midpoint, read priority 000b
// - mask one blocks, all set at reset
// - mask low bit 0 sets all masks
// - pending follows request every clock
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "ifp_map.svh"

module ifp_top
    import ifp_pkg::*;
#(
    // vector of source 0; sources add their number
    parameter logic [7:0] VECTOR_BASE = 8'h40,
    // vector answered when nothing requests at the level
    parameter logic [7:0] SPURIOUS_VECTOR = 8'h18
)(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // source request lines, bit 0 unused
    input wire logic [63:0] src_req,
    // level requests of the second controller instance
    input wire logic [7:1] peer_level,
    // acknowledge from the core
    input wire logic ack_req,
    input wire logic [2:0] ack_level,
    // answers to the core
    output logic [2:0] ipl,
    output logic ack_done,
    output logic [7:0] ack_vector,
    // own level summary for the other instance
    output logic [7:1] level_out
);

    // ****************************************
    // parameter check
    // ****************************************
    if (VECTOR_BASE > 8'hc0) begin : g_bad_base
        $error("vector base leaves no room for 64 sources");
    end

    // ****************************************
    // declarations
    // ****************************************
    ifp_state_t s; // registered state
    ifp_state_t next_s; // next state
    ifp_icr_arr_t icr_v; // control bytes as read back
    logic [63:0] active; // requests seen by the search
    logic [7:1] level_hit; // levels with a request
    ifp_win_t win; // acknowledge winner
    logic [31:0] rd_data; // read decode data
    logic [1:0] rd_resp; // read decode answer

    // ****************************************
    // control view
    // ****************************************
    // fixed sources show level = number and priority 000b
    always_comb begin
        icr_v = s.icr;
        icr_v[0] = `IFP_ICR_RESET;
        for (int i = 1; i < 8; i++) begin
            icr_v[i] = {2'b00, 3'(i), 3'b000};
        end
    end

    // ****************************************
    // request path
    // ****************************************
    // force ignores mask
    assign active = ((s.pend & ~s.mask) | s.force_bits) & 64'hffff_ffff_ffff_fffe;

    // per level, one term per source
    for (genvar l = 1; l < 8; l++) begin : g_lvl
        logic [63:0] hit; // sources requesting at level l
        for (genvar i = 0; i < 64; i++) begin : g_src
            assign hit[i] = active[i] &&
                (icr_v[i][`IFP_ICR_LVL_MSB:`IFP_ICR_LVL_LSB] == 3'(l));
        end
        assign level_hit[l] = |hit;
    end

    // ****************************************
    // acknowledge search
    // ****************************************
    ifp_arbiter u_arb (
        .active(active),
        .icr(icr_v),
        .level(ack_level),
        .win(win)
    );

    // ****************************************
    // read decode
    // ****************************************
    // unmapped reads answer decode error with zero data
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_resp = `IFP_RESP_OKAY;
        if (s_axi_araddr[11:8] == `IFP_PAGE_ICR) begin
            rd_data = {24'h00_0000, icr_v[s_axi_araddr[7:2]]};
        end else begin
            unique case ({s_axi_araddr[11:2], 2'b00})
                `IFP_OFF_FORCE_HIGH: rd_data = s.force_bits[63:32];
                `IFP_OFF_FORCE_LOW: rd_data = s.force_bits[31:0];
                `IFP_OFF_MASK_HIGH: rd_data = s.mask[63:32];
                `IFP_OFF_MASK_LOW: rd_data = s.mask[31:0];
                `IFP_OFF_PEND_HIGH: rd_data = s.pend[63:32];
                // bit 0 of pending is reserved
                `IFP_OFF_PEND_LOW: rd_data = {s.pend[31:1], 1'b0};
                `IFP_OFF_LEVEL_SUM: rd_data = {24'h00_0000, s.summary, 1'b0};
                `IFP_OFF_ACK_LP: rd_data = {24'h00_0000, s.ack_lp};
                default: rd_resp = `IFP_RESP_DECERR;
            endcase
        end
    end

    // ****************************************
    // byte lane merge
    // ****************************************
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = data[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [31:0] m; // merged write word
        logic [5:0] idx; // control index of a write
        m = 32'h0000_0000;
        idx = 6'h00;
        next_s = s;
        // synchronisers; first stage read only by second
        next_s.req_meta = src_req;
        next_s.pend = s.req_meta;
        next_s.peer_meta = peer_level;
        next_s.peer = s.peer_meta;

        next_s.summary = level_hit;

        next_s.ipl = 3'h0;
        for (int l = 1; l < 8; l++) begin
            if (s.summary[l] || s.peer[l]) begin
                next_s.ipl = 3'(l);
            end
        end

        // acknowledge answer, one cycle pulse
        next_s.ack_done = 1'b0;
        if (ack_req) begin
            next_s.ack_done = 1'b1;
            next_s.ack_vector = win.found ?
                VECTOR_BASE + {2'b00, win.src} : SPURIOUS_VECTOR;
            next_s.ack_lp = {1'b0, ack_level,
                win.found ? win.acked_priority_field : 4'h0};
        end

        // write response taken
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        // write address taken
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        // write data taken
        if (s_axi_wvalid && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end

        // both halves held: perform the write
        if (s.aw_held && s.w_held && !s.bvalid) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = `IFP_RESP_OKAY;
            idx = s.awaddr[7:2];
            if (s.awaddr[11:8] == `IFP_PAGE_ICR) begin
                if (idx >= `IFP_ICR_FIRST_RW && s.wstrb[0]) begin
                    next_s.icr[idx] = s.wdata[7:0] & `IFP_ICR_WMASK;
                end
            end else begin
                unique case ({s.awaddr[11:2], 2'b00})
                    `IFP_OFF_FORCE_HIGH: begin
                        next_s.force_bits[63:32] =
                            merge(s.force_bits[63:32], s.wdata, s.wstrb);
                    end
                    `IFP_OFF_FORCE_LOW: begin
                        m = merge(s.force_bits[31:0], s.wdata, s.wstrb);
                        next_s.force_bits[31:0] = m & `IFP_FORCE_LOW_WMASK;
                    end
                    // mask high word
                    `IFP_OFF_MASK_HIGH: begin
                        next_s.mask[63:32] =
                            merge(s.mask[63:32], s.wdata, s.wstrb);
                    end
                    // mask low word with mask-all bit
                    `IFP_OFF_MASK_LOW: begin
                        m = merge(s.mask[31:0], s.wdata, s.wstrb);
                        next_s.mask[31:0] = m;
                        if (m[0]) begin
                            next_s.mask = `IFP_MASK_RESET;
                        end
                    end
                    // read-only words ignore writes
                    `IFP_OFF_PEND_HIGH, `IFP_OFF_PEND_LOW,
                    `IFP_OFF_LEVEL_SUM, `IFP_OFF_ACK_LP: begin
                        next_s.bresp = `IFP_RESP_OKAY;
                    end
                    default: next_s.bresp = `IFP_RESP_DECERR;
                endcase
            end
        end
        // ready while the holding slot is free
        next_s.awready = !next_s.aw_held;
        next_s.wready = !next_s.w_held;

        // read data taken
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        // read address taken, answer next cycle
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_data;
            next_s.rresp = rd_resp;
        end
        next_s.arready = !next_s.rvalid;
    end

    // ****************************************
    // state register
    // ****************************************
    // synchronous reset; everything zero except the masks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.force_bits <= `IFP_FORCE_RESET;
            s.mask <= `IFP_MASK_RESET;
            s.icr <= {64{`IFP_ICR_RESET}};
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign ipl = s.ipl;
    assign ack_done = s.ack_done;
    assign ack_vector = s.ack_vector;
    assign level_out = s.summary;

endmodule : ifp_top
`default_nettype wire

// *** verif/ifp_top_checker.sv ***
// checker for the force/level/priority block, bound to its top
// assumes: one clock aclk, synchronous active-low aresetn
`timescale 1ns/10ps
`default_nettype none

module ifp_top_checker
    import ifp_pkg::*;
#(
    parameter logic [7:0] VECTOR_BASE = 8'h40,
    parameter logic [7:0] SPURIOUS_VECTOR = 8'h18
)(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rready,
    // core side
    input wire logic [7:1] peer_level,
    input wire logic ack_req,
    input wire logic [2:0] ipl,
    input wire logic ack_done,
    input wire logic [7:0] ack_vector,
    input wire logic [7:1] level_out
);
    // ****
    // helpers
    // ****
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [2:0] up_cnt; // cycles since release, stops at 4
    // count until the level pipeline is filled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h4) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    // highest set level, 0 when none
    function automatic logic [2:0] top_lvl(input logic [7:1] v);
        top_lvl = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (v[i]) begin
                top_lvl = i[2:0];
            end
        end
    endfunction : top_lvl
    sequence wr_both_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && !s_axi_bvalid;
    endsequence
    sequence wr_resp_s;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    sequence rd_take_s;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // ****
    // assertions
    // ****
    rst_quiet_a: assert property ($rose(aresetn) |-> !s_axi_awready
        && !s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && !ack_done)
        else $error("outputs not idle after reset");
    wr_answer_a: assert property (wr_both_s |=> wr_resp_s)
        else $error("write response not two cycles after take");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rd_answer_a: assert property (rd_take_s |=> s_axi_rvalid
        && !s_axi_arready)
        else $error("read data not one cycle after take");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    ack_pulse_a: assert property (ack_req |=> ack_done)
        else $error("ack_done missing after ack_req");
    ack_idle_a: assert property (!ack_req |=> !ack_done
        && $stable(ack_vector))
        else $error("ack answer without request");
    vec_range_a: assert property (ack_done |->
        ack_vector == SPURIOUS_VECTOR || (ack_vector > VECTOR_BASE
        && ack_vector < VECTOR_BASE + 8'h40))
        else $error("ack vector outside source range");
    ipl_code_a: assert property (up_cnt == 3'h4 |->
        ipl == top_lvl($past(level_out) | $past(peer_level, 3)))
        else $error("ipl not highest merged level");
endmodule : ifp_top_checker

bind ifp_top ifp_top_checker #(.VECTOR_BASE(VECTOR_BASE),
    .SPURIOUS_VECTOR(SPURIOUS_VECTOR)) u_chk (.*);

`default_nettype wire

// *** verif/ifp_core_model.sv ***
// core model: one acknowledge strobe per bench command
// assumes: same clock as the block, command held one cycle
`timescale 1ns/10ps
`default_nettype none

module ifp_core_model
    import ifp_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench command
    input wire logic go,
    input wire logic [2:0] go_level,
    input wire logic [3:0] go_wait,
    // acknowledge to the block
    output logic ack_req,
    output logic [2:0] ack_level
);
    logic busy; // strobe scheduled
    logic [3:0] cnt; // cycles still to wait
    logic [2:0] lvl; // level to acknowledge
    // level line only means something with the strobe, else scrambled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy <= 1'b0;
            ack_req <= 1'b0;
            ack_level <= 3'h0;
        end else if (go) begin
            busy <= 1'b1;
            cnt <= go_wait;
            lvl <= go_level;
            ack_req <= 1'b0;
            ack_level <= ~ack_level;
        end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            ack_req <= 1'b1;
            ack_level <= lvl;
        end else begin
            cnt <= cnt - 4'h1;
            ack_req <= 1'b0;
            ack_level <= ~ack_level;
        end
    end
endmodule : ifp_core_model

`default_nettype wire

// *** verif/ifp_top_tb.sv ***
// self-checking bench for the force/level/priority block
// assumes: checker bound to the top, core model on the ack side
`timescale 1ns/10ps
`default_nettype none
`include "ifp_map.svh"

module ifp_top_tb
    import ifp_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, ack_req, ack_done;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, go_wait;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [63:0] src_req;
    logic [7:1] peer_level, level_out;
    logic [2:0] ack_level, ipl, go_level;
    logic [7:0] ack_vector;
    logic go;
    logic [33:0] bus_q[$]; // expected {resp, data}
    logic [7:0] ack_q[$]; // expected vectors
    int n_mismatch = 0;
    int checked = 0;

    ifp_top u_dut (.*);
    ifp_core_model u_core (.*);

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // ****
    // compare and closing
    // ****
    task automatic cmp_bus(input logic [33:0] e, input logic [33:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] bus resp_data exp %h got %h", e, g);
        end
    endtask : cmp_bus
    task automatic cmp_ack(input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] ack_vector exp %h got %h", e, g);
        end
    endtask : cmp_ack
    task automatic cmp_lvl(input logic [2:0] e);
        checked++;
        if (ipl !== e) begin
            n_mismatch++;
            $display("[ERR] ipl exp %h got %h", e, ipl);
        end
    endtask : cmp_lvl
    // level summary handed to the other instance
    task automatic cmp_sum(input logic [7:1] e);
        checked++;
        if (level_out !== e) begin
            n_mismatch++;
            $display("[ERR] level_out exp %h got %h", e, level_out);
        end
    endtask : cmp_sum
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    task automatic give_up();
        n_mismatch++;
        $display("[ERR] handshake exp answer got timeout");
        tally_and_finish();
    endtask : give_up

    // results appear: take the oldest note and compare
    always @(posedge aclk) begin
        if (aresetn && s_axi_rvalid && s_axi_rready) begin
            cmp_bus(bus_q.pop_front(), {s_axi_rresp, s_axi_rdata});
        end
        if (aresetn && s_axi_bvalid && s_axi_bready) begin
            cmp_bus(bus_q.pop_front(), {s_axi_bresp, 32'h0});
        end
        if (aresetn && ack_done) begin
            cmp_ack(ack_q.pop_front(), ack_vector);
        end
    end

    // ****
    // bus and core tasks
    // ****
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n;
        n = 0;
        bus_q.push_back({r, 32'h0});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        if (!s_axi_bvalid) give_up();
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        int n;
        n = 0;
        bus_q.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        if (!s_axi_rvalid) give_up();
        s_axi_rready <= 1'b0;
    endtask : rd
    // core acknowledge, then the captured level/priority byte
    task automatic ack(input logic [2:0] l, input logic [3:0] w,
                       input logic [7:0] v, input logic [7:0] lp);
        int n;
        n = 0;
        ack_q.push_back(v);
        @(posedge aclk);
        go <= 1'b1;
        go_level <= l;
        go_wait <= w;
        @(posedge aclk);
        go <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (!ack_done && n < 30);
        if (!ack_done) give_up();
        rd(`IFP_OFF_ACK_LP, {26'h0, lp});
    endtask : ack
    function automatic logic [11:0] ctl(input int n);
        return 12'h100 + 12'(n * 4);
    endfunction : ctl

    // ****
    // main sequence
    // ****
    initial begin
        logic [31:0] rv;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, go} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        {s_axi_wstrb, go_level, go_wait} = 11'h780;
        src_req = 64'h0;
        peer_level = 7'h0;
        rv = $urandom(32'h7f48a544);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`IFP_OFF_FORCE_LOW, 34'h0);
        rd(`IFP_OFF_MASK_HIGH, 34'hffff_ffff);
        rd(12'h020, {2'h3, 32'h0});
        wr(12'h020, 32'h1, 2'h3);
        for (int i = 1; i < 8; i++) begin
            rd(ctl(i), {26'h0, 2'h0, i[2:0], 3'h0});
        end
        wr(ctl(5), 32'h3f, 2'h0);
        rd(ctl(5), 34'h28);
        rd(ctl(8), 34'h0);
        wr(ctl(8), 32'hff, 2'h0);
        rd(ctl(8), 34'h3f);
        // control byte lane not strobed: write dropped
        s_axi_wstrb <= 4'he;
        wr(ctl(9), 32'h3f, 2'h0);
        s_axi_wstrb <= 4'hf;
        rd(ctl(9), 34'h0);
        wr(`IFP_OFF_FORCE_LOW, 32'hffff_ffff, 2'h0);
        rd(`IFP_OFF_FORCE_LOW, 34'hffff_fffe);
        rv = $urandom();
        wr(`IFP_OFF_FORCE_HIGH, rv, 2'h0);
        rd(`IFP_OFF_FORCE_HIGH, {2'h0, rv});
        wr(ctl(8), 32'h0, 2'h0);
        wr(ctl(20), 32'h22, 2'h0);
        wr(ctl(21), 32'h25, 2'h0);
        wr(ctl(22), 32'h1b, 2'h0);
        wr(ctl(23), 32'h1c, 2'h0);
        wr(`IFP_OFF_FORCE_LOW, 32'h0010_0000, 2'h0);
        // summary is read-only: write answered but ignored
        wr(`IFP_OFF_LEVEL_SUM, 32'hff, 2'h0);
        repeat (6) @(posedge aclk);
        rd(`IFP_OFF_LEVEL_SUM, 34'h10);
        cmp_sum(7'h08);
        cmp_lvl(3'h4);
        wr(`IFP_OFF_MASK_LOW, 32'hff1f_fff6, 2'h0);
        // source 0 line driven too: it must stay invisible
        src_req <= 64'h0000_0100_0060_0009;
        repeat (6) @(posedge aclk);
        rd(`IFP_OFF_PEND_HIGH, 34'h100);
        rd(`IFP_OFF_PEND_LOW, 34'h0060_0008);
        rd(`IFP_OFF_LEVEL_SUM, 34'h18);
        cmp_sum(7'h0c);
        ack(3'h4, 4'h0, 8'h55, 8'h45);
        ack(3'h3, 4'h3, 8'h43, 8'h38);
        src_req <= 64'h0000_0100_00e0_0008;
        repeat (6) @(posedge aclk);
        ack(3'h3, 4'h0, 8'h57, 8'h34);
        ack(3'h6, 4'h5, 8'h18, 8'h60);
        peer_level <= 7'h40;
        repeat (6) @(posedge aclk);
        cmp_lvl(3'h7);
        peer_level <= 7'h0;
        wr(`IFP_OFF_MASK_LOW, 32'h1, 2'h0);
        rd(`IFP_OFF_MASK_HIGH, 34'hffff_ffff);
        repeat (6) @(posedge aclk);
        rd(`IFP_OFF_LEVEL_SUM, 34'h10);
        cmp_sum(7'h08);
        ack(3'h4, 4'h1, 8'h54, 8'h42);
        tally_and_finish();
    end
endmodule : ifp_top_tb

`default_nettype wire
